// [rtl/pih_ext_filter.sv]
// pih_ext_filter: three-sample glitch filter for one external source.
// assumes src_clk_en_in marks undivided source-clock ticks on ref_clk_in.
module pih_ext_filter
	import pih_pkg::*;
(
	// clock and reset
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	// sampling
	input  wire logic src_clk_en_in,
	input  wire logic raw_in,
	// result
	output logic      event_out
);

	logic [PIH_FILTER_LEN-1:0] shift;
	logic                      seen;

	// a pulse must stand for all samples before it counts
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			shift <= '0;
		end else if (src_clk_en_in) begin
			shift <= {shift[PIH_FILTER_LEN-2:0], raw_in};
		end
	end

	// one event per asserted pulse; shorter pulses never reach all ones
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			seen      <= 1'b0;
			event_out <= 1'b0;
		end else begin
			event_out <= (&shift) && !seen;
			seen      <= &shift;
		end
	end

endmodule // pih_ext_filter

// [rtl/pih_handler.sv]
// pih_handler: prioritized interrupt handler with APB register access.
// assumes sources are synchronous; the core honours the vector strobes.
module pih_handler
	import pih_pkg::*;
#(
	parameter int NUM_SRC = PIH_NUM_SRC
)(
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// sources
	input  wire logic [NUM_SRC-1:0]     int_cond_in,
	input  wire logic [NUM_SRC-1:0]     flag_clear_in,
	input  wire logic [PIH_NUM_EXT-1:0] ext_raw_in,
	input  wire logic                   src_clk_en_in,
	input  wire logic                   stop_mode_in,
	// core
	input  wire logic        prefix_write_in,
	input  wire logic        code_ptr_access_in,
	input  wire logic        return_from_handler_in,
	input  wire logic [15:0] next_pc_in,
	input  wire logic [15:0] pop_data_in,
	output logic             fetch_cancel_out,
	output logic             push_out,
	output logic [15:0]      push_data_out,
	output logic             pop_out,
	output logic             ip_load_out,
	output logic [15:0]      ip_value_out,
	output logic [1:0]       in_service_level_out,
	output logic             switchback_out
);

	////////////////////////////////////////////////////////////////////////
	// registers

	logic                 global_irq_enable;
	logic [15:0]          priority_select_low;
	logic [15:0]          priority_select_high;
	logic [NUM_SRC-1:0]   local_en;
	logic [PIH_NUM_EXT-1:0] ext_en;
	logic [NUM_SRC-1:0]   flags;
	logic [2:0]           clkdiv;
	logic [1:0]           in_service_level;
	logic [1:0]           saved_level;
	logic [3:0]           serve_src;
	logic                 serve_default;
	pih_state_e           state;
	logic                 window;

	logic apb_wr;
	logic apb_rd;
	logic hit;
	assign apb_wr = psel_in && penable_in && pwrite_in;
	// read data captured in setup so it stands at the access edge
	assign apb_rd = psel_in && !penable_in && !pwrite_in;
	assign pready_out = 1'b1;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == PIH_OFF_CONTROL) || (a == PIH_OFF_PRIO_LOW) ||
			(a == PIH_OFF_PRIO_HIGH) || (a == PIH_OFF_STATUS) ||
			(a == PIH_OFF_LOCAL_EN) || (a == PIH_OFF_EXT_EN) ||
			(a == PIH_OFF_FLAGS) || (a == PIH_OFF_CLKDIV);
	endfunction

	assign hit = mapped(paddr_in);
	assign pslverr_out = psel_in && penable_in && !hit;

	function automatic logic [1:0] level_of(input int idx,
		input logic [15:0] lo, input logic [15:0] hi);
		logic [31:0] all;
		all = {hi, lo};
		level_of = all[2*idx +: 2];
	endfunction

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			global_irq_enable <= 1'b0;
			priority_select_low  <= PIH_RST_PRIO;
			priority_select_high <= PIH_RST_PRIO;
			local_en <= NUM_SRC'(PIH_RST_EN);
			ext_en   <= PIH_RST_EN;
			clkdiv   <= PIH_RST_CLKDIV;
		end else if (apb_wr) begin
			unique case (paddr_in)
				PIH_OFF_CONTROL:
					global_irq_enable <= pwdata_in[PIH_CTL_GIE_BIT];
				PIH_OFF_PRIO_LOW:  priority_select_low  <= pwdata_in[15:0];
				PIH_OFF_PRIO_HIGH: priority_select_high <= pwdata_in[15:0];
				PIH_OFF_LOCAL_EN:  local_en <= pwdata_in[NUM_SRC-1:0];
				PIH_OFF_EXT_EN:    ext_en   <= pwdata_in[15:0];
				PIH_OFF_CLKDIV:    clkdiv   <= pwdata_in[2:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (apb_rd) begin
			unique case (paddr_in)
				PIH_OFF_CONTROL:
					prdata_out <= {31'h0, global_irq_enable};
				PIH_OFF_PRIO_LOW:  prdata_out <= {16'h0, priority_select_low};
				PIH_OFF_PRIO_HIGH: prdata_out <= {16'h0, priority_select_high};
				PIH_OFF_STATUS:
					prdata_out <= {20'h0, serve_src, 5'h0,
						(state != PIH_ST_RUN), in_service_level};
				PIH_OFF_LOCAL_EN:  prdata_out <= 32'(local_en);
				PIH_OFF_EXT_EN:    prdata_out <= {16'h0, ext_en};
				PIH_OFF_FLAGS:     prdata_out <= 32'(flags);
				PIH_OFF_CLKDIV:    prdata_out <= {29'h0, clkdiv};
				default:           prdata_out <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// external filters and divide-dependent recognition

	logic [PIH_NUM_EXT-1:0] ext_evt;
	logic [PIH_NUM_EXT-1:0] ext_d1;
	logic [PIH_NUM_EXT-1:0] ext_d2;
	logic [PIH_NUM_EXT-1:0] ext_ready;

	genvar g;
	generate
		for (g = 0; g < PIH_NUM_EXT; g++) begin : g_filt
			pih_ext_filter u_filt (
				.ref_clk_in    (ref_clk_in),
				.rst_in        (rst_in),
				.src_clk_en_in (src_clk_en_in),
				.raw_in        (ext_raw_in[g]),
				.event_out     (ext_evt[g])
			);
		end
	endgenerate

	// filtered events reach the handler later at low divide ratios
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			ext_d1 <= '0;
			ext_d2 <= '0;
		end else begin
			ext_d1 <= ext_evt;
			ext_d2 <= ext_d1;
		end
	end

	always_comb begin
		if (clkdiv[PIH_CDIV_POWER_MGMT_ENABLE_BIT] || clkdiv[1]) begin
			ext_ready = ext_evt;
		end else if (clkdiv[0]) begin
			ext_ready = ext_d1;
		end else begin
			ext_ready = ext_d2;
		end
	end

	// filter runs undivided, so no wait for the slow clock
	assign switchback_out = |(ext_evt & ext_en);

	////////////////////////////////////////////////////////////////////////
	// flags and requests

	logic [NUM_SRC-1:0] cond_all;
	always_comb begin
		cond_all = int_cond_in;
		cond_all[PIH_SRC_EXT_LO] = int_cond_in[PIH_SRC_EXT_LO] |
			(|(ext_ready[7:0] & ext_en[7:0]));
		cond_all[PIH_SRC_EXT_HI] = int_cond_in[PIH_SRC_EXT_HI] |
			(|(ext_ready[15:8] & ext_en[15:8]));
	end

	// set wins over clear; local and global enables do not gate the flag
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~flag_clear_in) | cond_all;
		end
	end

	logic [NUM_SRC-1:0] gate;
	logic [NUM_SRC-1:0] req;
	always_comb begin
		gate = {NUM_SRC{global_irq_enable}};
		gate[PIH_SRC_PFAIL] = 1'b1;
		req = flags & local_en & gate;
	end

	// arbitration: level first, then natural order
	logic       win_valid;
	logic [3:0] win_src;
	logic [1:0] win_lvl;
	always_comb begin
		win_valid = 1'b0;
		win_src   = 4'h0;
		win_lvl   = PIH_LEVEL_IDLE;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (req[i] && level_of(i, priority_select_low,
				priority_select_high) < win_lvl) begin
				win_valid = 1'b1;
				win_src   = 4'(i);
				win_lvl   = level_of(i, priority_select_low,
					priority_select_high);
			end
		end
	end

	// masked flags with no enabled path keep the served source's vector, not the default
	logic masked_pending;
	logic medium_in_stop;
	assign masked_pending = |(flags & ~(local_en & gate)) && !win_valid;
	assign medium_in_stop = stop_mode_in && win_valid &&
		(win_lvl == PIH_LEVEL_MEDIUM);

	logic accept;
	assign accept = win_valid && (win_lvl < in_service_level);

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			window <= 1'b0;
		end else begin
			window <= prefix_write_in || code_ptr_access_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// vectoring sequence

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state            <= PIH_ST_RUN;
			in_service_level <= PIH_LEVEL_IDLE;
			saved_level      <= PIH_LEVEL_IDLE;
			serve_src        <= 4'h0;
			serve_default    <= 1'b0;
		end else begin
			unique case (state)
				PIH_ST_RUN: begin
					if (return_from_handler_in) begin
						state <= PIH_ST_RET;
					end else if (accept) begin
						state     <= PIH_ST_STALL;
						serve_src <= win_src;
						serve_default <= medium_in_stop;
						saved_level   <= win_lvl;
					end
				end
				PIH_ST_STALL: begin
					// instruction in flight may open a window
					if (!window && !prefix_write_in) begin
						state <= PIH_ST_VECTOR;
					end
				end
				PIH_ST_VECTOR: begin
					state            <= PIH_ST_RUN;
					in_service_level <= saved_level;
				end
				PIH_ST_RET: begin
					state            <= PIH_ST_RUN;
					in_service_level <= PIH_LEVEL_IDLE;
				end
				default: state <= PIH_ST_RUN;
			endcase
		end
	end

	// default vector also catches a served request that is gone, unless masked flags wait with no winner
	logic [15:0] vec;
	always_comb begin
		if (serve_default || (!req[serve_src] && !masked_pending)) begin
			vec = PIH_DEFAULT_VEC;
		end else begin
			// one fixed step per natural priority; source 15 shares the default vector slot
			vec = PIH_VECTOR_BASE + 16'(serve_src) * PIH_VECTOR_STEP;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			fetch_cancel_out <= 1'b0;
			push_out         <= 1'b0;
			push_data_out    <= 16'h0000;
			pop_out          <= 1'b0;
			ip_load_out      <= 1'b0;
			ip_value_out     <= 16'h0000;
		end else begin
			fetch_cancel_out <= (state == PIH_ST_STALL) && !window &&
				!prefix_write_in;
			push_out         <= (state == PIH_ST_VECTOR);
			push_data_out    <= next_pc_in;
			pop_out          <= (state == PIH_ST_RET);
			ip_load_out      <= (state == PIH_ST_VECTOR) ||
				(state == PIH_ST_RET);
			if (state == PIH_ST_VECTOR) begin
				ip_value_out <= vec;
			end else if (state == PIH_ST_RET) begin
				ip_value_out <= pop_data_in;
			end
		end
	end

	assign in_service_level_out = in_service_level;

endmodule // pih_handler

// [shared/pih_pkg.sv]
// pih_pkg: constants, register map and types for the interrupt handler.
// assumes a 32-bit APB slave and a 16-bit core with a word-addressed stack.
package pih_pkg;

	localparam int PIH_NUM_SRC = 16;
	localparam int PIH_NUM_EXT = 16;

	// fixed vector table; each source sits 8 words above the previous one
	localparam logic [15:0] PIH_VECTOR_BASE  = 16'h0020;
	localparam logic [15:0] PIH_VECTOR_STEP  = 16'h0008;
	localparam logic [15:0] PIH_DEFAULT_VEC  = 16'h0098;

	// in-service level
	localparam logic [1:0]  PIH_LEVEL_IDLE   = 2'h3;
	localparam logic [1:0]  PIH_LEVEL_MEDIUM = 2'h1;

	// source numbers by natural priority
	localparam int PIH_SRC_PFAIL = 0;
	localparam int PIH_SRC_EXT_LO = 2;
	localparam int PIH_SRC_EXT_HI = 5;

	// glitch filter length in undivided source clocks
	localparam int PIH_FILTER_LEN = 3;

	// register byte offsets
	localparam logic [7:0] PIH_OFF_CONTROL   = 8'h00;
	localparam logic [7:0] PIH_OFF_PRIO_LOW  = 8'h04;
	localparam logic [7:0] PIH_OFF_PRIO_HIGH = 8'h08;
	localparam logic [7:0] PIH_OFF_STATUS    = 8'h0C;
	localparam logic [7:0] PIH_OFF_LOCAL_EN  = 8'h10;
	localparam logic [7:0] PIH_OFF_EXT_EN    = 8'h14;
	localparam logic [7:0] PIH_OFF_FLAGS     = 8'h18;
	localparam logic [7:0] PIH_OFF_CLKDIV    = 8'h1C;

	// control, status and clock-divide register fields
	localparam int PIH_CTL_GIE_BIT  = 0;
	localparam int PIH_STS_LVL_LSB  = 0;
	localparam int PIH_STS_BUSY_BIT = 2;
	localparam int PIH_STS_SRC_LSB  = 8;
	localparam int PIH_CDIV_POWER_MGMT_ENABLE_BIT = 2;

	// reset values
	localparam logic [15:0] PIH_RST_PRIO   = 16'h0000;
	localparam logic [15:0] PIH_RST_EN     = 16'h0000;
	localparam logic [2:0]  PIH_RST_CLKDIV = 3'h0;

	typedef enum logic [1:0] {
		PIH_ST_RUN,
		PIH_ST_STALL,
		PIH_ST_VECTOR,
		PIH_ST_RET
	} pih_state_e;

endpackage

// [tb/pih_assertions.sv]
// pih_assertions: timing checks on the handler's ports.
// assumes one clock domain and a synchronous active-high reset.
module pih_assertions
	import pih_pkg::*;
(
	// watched ports
	input wire logic        ref_clk_in,
	input wire logic        rst_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	input wire logic        prefix_write_in,
	input wire logic        return_from_handler_in,
	input wire logic [15:0] pop_data_in,
	input wire logic        fetch_cancel_out,
	input wire logic        push_out,
	input wire logic        pop_out,
	input wire logic        ip_load_out,
	input wire logic [15:0] ip_value_out,
	input wire logic [1:0]  in_service_level_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////////////////////////////////////
	property p_rdy; psel_in && penable_in |-> pready_out; endproperty
	a_rdy: assert property (p_rdy) else $error("ready missing");
	property p_err; pslverr_out |-> psel_in && penable_in; endproperty
	a_err: assert property (p_err) else $error("stray slave error");
	property p_cancel;
		fetch_cancel_out |=> push_out && ip_load_out;
	endproperty
	a_cancel: assert property (p_cancel)
		else $error("cancel without push");
	property p_lvl;
		push_out |-> in_service_level_out < $past(in_service_level_out);
	endproperty
	a_lvl: assert property (p_lvl)
		else $error("level not raised");
	property p_vec;
		push_out |-> ip_value_out[2:0] == 3'h0 &&
			ip_value_out inside {[PIH_VECTOR_BASE:PIH_DEFAULT_VEC]};
	endproperty
	a_vec: assert property (p_vec)
		else $error("vector off table");
	property p_pop;
		pop_out |-> ip_load_out && in_service_level_out == PIH_LEVEL_IDLE
			&& ip_value_out == $past(pop_data_in);
	endproperty
	a_pop: assert property (p_pop)
		else $error("bad return");
	property p_ret; return_from_handler_in |=> !fetch_cancel_out [*2];
	endproperty
	a_ret: assert property (p_ret)
		else $error("return interrupted");
	property p_gap; fetch_cancel_out |=> !fetch_cancel_out [*2]; endproperty
	a_gap: assert property (p_gap)
		else $error("interrupts too close");
	property p_pfx; prefix_write_in |=> !fetch_cancel_out; endproperty
	a_pfx: assert property (p_pfx)
		else $error("service in window");
endmodule // pih_assertions

bind pih_handler pih_assertions pih_assertions_inst (
	.ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .prefix_write_in(prefix_write_in),
	.return_from_handler_in(return_from_handler_in),
	.pop_data_in(pop_data_in), .fetch_cancel_out(fetch_cancel_out),
	.push_out(push_out), .pop_out(pop_out), .ip_load_out(ip_load_out),
	.ip_value_out(ip_value_out),
	.in_service_level_out(in_service_level_out)
);

// [tb/pih_core_model.sv]
// pih_core_model: core side of the handler, program counter and stack.
// assumes one-clock push and pop pulses and a nesting depth below four.
module pih_core_model (
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	// from handler
	input  wire logic        push_in,
	input  wire logic [15:0] push_data_in,
	input  wire logic        pop_in,
	// to handler
	output logic [15:0]      next_pc_out,
	output logic [15:0]      pop_data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] stack [4];
	logic [1:0]  sp;
	// empty stack shows a moving pattern so stale data cannot pass
	assign pop_data_out = (sp == 2'h0) ? ~next_pc_out : stack[sp - 2'h1];
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			next_pc_out <= 16'h0100;
			sp <= 2'h0;
		end else begin
			next_pc_out <= next_pc_out + 16'h0001;
			if (push_in) begin
				stack[sp] <= push_data_in;
				sp <= sp + 2'h1;
			end else if (pop_in) begin
				sp <= sp - 2'h1;
			end
		end
	end
endmodule // pih_core_model

// [tb/testbench.sv]
// testbench: random and corner-case interrupt traffic for the handler.
// assumes pready answers at once and read data stands in the access phase.
module testbench
	import pih_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0;
	logic        pwr = 1'b0, prefix_hold_reg = 1'b0, ret = 1'b0, stop = 1'b0;
	logic        err, pready, perr, push, pop, sb;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] cond = 16'h0, clr = 16'h0, ext = 16'h0;
	logic [15:0] npc, popd, pushd, ipv, pr, m;
	logic [1:0]  lvl;
	int          error_cnt = 0, n_tests = 0, npush = 0, nsb = 0, k, w;
	longint      t0, lt [3];
	int          seed = 32'h4144e3a2;

	pih_handler pih_handler_inst (
		.ref_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
		.int_cond_in(cond), .flag_clear_in(clr), .ext_raw_in(ext),
		.src_clk_en_in(1'b1), .stop_mode_in(stop),
		.prefix_write_in(prefix_hold_reg), .code_ptr_access_in(1'b0),
		.return_from_handler_in(ret), .next_pc_in(npc),
		.pop_data_in(popd), .fetch_cancel_out(), .push_out(push),
		.push_data_out(pushd), .pop_out(pop), .ip_load_out(),
		.ip_value_out(ipv), .in_service_level_out(lvl),
		.switchback_out(sb)
	);
	pih_core_model pih_core_model_inst (
		.ref_clk_in(clk), .rst_in(rst), .push_in(push),
		.push_data_in(pushd), .pop_in(pop), .next_pc_out(npc),
		.pop_data_out(popd)
	);
	////////////////////////////////////////////////////////////////
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (push === 1'b1) npush++;
		if (sb === 1'b1) nsb++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		// answer and read data both taken at the ready edge
		err = perr;
		rd = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic pulse(input logic [15:0] c, input logic p);
		@(posedge clk);
		cond <= c;
		@(posedge clk);
		cond <= 16'h0;
		prefix_hold_reg <= p;
		@(posedge clk);
		prefix_hold_reg <= 1'b0;
	endtask
	task automatic xp(input int n);
		@(posedge clk);
		ext <= 16'h0001;
		t0 = $time;
		repeat (n) @(posedge clk);
		ext <= 16'h0000;
	endtask
	// level 3 skips the level compare
	task automatic svc(input logic [15:0] v, input logic [1:0] l);
		for (int i = 0; i < 40 && push !== 1'b1; i++) @(negedge clk);
		chk(32'(ipv), 32'(v));
		if (l != 2'h3) chk(32'(lvl), 32'(l));
	endtask
	task automatic rtn(input logic [15:0] c);
		@(posedge clk);
		clr <= c;
		ret <= 1'b1;
		@(posedge clk);
		clr <= 16'h0;
		ret <= 1'b0;
		for (int i = 0; i < 20 && pop !== 1'b1; i++) @(negedge clk);
		chk(32'(lvl), 32'h3);
	endtask
	task automatic quiet();
		k = npush;
		repeat (10) @(posedge clk);
		chk(32'(npush), 32'(k));
	endtask
	function automatic int win(input logic [15:0] mk, input logic [15:0] p);
		int b;
		b = -1;
		for (int n = 0; n < 8; n++)
			if (mk[n] && (b < 0 || p[2*n+:2] < p[2*b+:2])) b = n;
		return b;
	endfunction
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		final_report();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		apb(1'b1, PIH_OFF_FLAGS, 32'hFFFF);
		for (k = 0; k < 8; k++) begin
			apb(1'b0, 8'(k * 4), 32'h0);
			chk(rd, (k == 3) ? 32'h3 : 32'h0);
		end
		apb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		chk(32'(err), 32'h1);
		$display("registers done");
		apb(1'b1, PIH_OFF_LOCAL_EN, 32'h001F);
		apb(1'b1, PIH_OFF_PRIO_LOW, 32'h0001);
		pulse(16'h0008, 1'b0);
		quiet();
		apb(1'b0, PIH_OFF_FLAGS, 32'h0);
		chk(rd, 32'h0008);
		pulse(16'h0001, 1'b0);
		svc(16'h0020, 2'h1);
		rtn(16'h0000);
		svc(16'h0020, 2'h1);
		rtn(16'h0009);
		$display("masking done");
		apb(1'b1, PIH_OFF_CONTROL, 32'h0001);
		for (k = 0; k < 6; k++) begin
			for (w = 0; w < 8; w++) pr[2*w+:2] = 2'($unsigned($random(seed)) % 3);
			apb(1'b1, PIH_OFF_PRIO_LOW, {16'h0, pr});
			pulse(16'h001A, 1'b0);
			m = 16'h001A;
			while (m != 16'h0) begin
				w = win(m, pr);
				svc(16'h0020 + 16'(8 * w), pr[2*w+:2]);
				rtn(16'(1 << w));
				m[w] = 1'b0;
			end
		end
		$display("arbitration done");
		apb(1'b1, PIH_OFF_PRIO_LOW, 32'h0248);
		pulse(16'h0002, 1'b0);
		svc(16'h0028, 2'h2);
		pulse(16'h0010, 1'b0);
		quiet();
		pulse(16'h0008, 1'b0);
		svc(16'h0038, 2'h1);
		rtn(16'h0008);
		svc(16'h0028, 2'h2);
		rtn(16'h0002);
		svc(16'h0040, 2'h2);
		rtn(16'h0010);
		$display("nesting done");
		apb(1'b1, PIH_OFF_PRIO_LOW, 32'h0244);
		pulse(16'h0002, 1'b1);
		svc(16'h0028, 2'h1);
		rtn(16'h0002);
		@(posedge clk);
		stop <= 1'b1;
		pulse(16'h0002, 1'b0);
		svc(PIH_DEFAULT_VEC, 2'h3);
		rtn(16'h0002);
		@(posedge clk);
		stop <= 1'b0;
		$display("window and stop done");
		apb(1'b1, PIH_OFF_EXT_EN, 32'h0001);
		xp(2);
		quiet();
		// ratios 1, 2 and 4: each step recognises one clock sooner
		for (w = 0; w < 3; w++) begin
			apb(1'b1, PIH_OFF_CLKDIV, 32'(w));
			xp(3);
			svc(16'h0030, 2'h0);
			lt[w] = ($time - t0) / 64'h28;
			rtn(16'h0004);
		end
		chk(32'(lt[0] - lt[1]), 32'h1);
		chk(32'(lt[0] - lt[2]), 32'h2);
		chk(32'(nsb), 32'h3);
		$display("filter done");
		final_report();
	end
endmodule // testbench
